// >>> tpw_pkg.sv
/*
 * Constants of the phase-correct PWM timer: register byte addresses,
 * field positions, reset values, mode codes and prescaler divisions.
 * Assumes a 32-bit AHB-Lite register bus, one word per register.
 */
package tpw_pkg;
	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTL_A    = 8'h44;
	localparam logic [7:0] ADDR_CTL_A_IO = 8'h24;
	localparam logic [7:0] ADDR_CTL_B    = 8'h48;
	localparam logic [7:0] ADDR_CMP_A    = 8'h4c;
	localparam logic [7:0] ADDR_CMP_B    = 8'h50;
	localparam logic [7:0] ADDR_COUNT    = 8'h54;
	localparam logic [7:0] ADDR_STATUS   = 8'h58;
	localparam logic [7:0] ADDR_CLEAR    = 8'h5c;
	localparam logic [7:0] ADDR_ENABLE   = 8'h60;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int OM_A_LSB  = 6;
	localparam int OM_B_LSB  = 4;
	localparam int WM_LSB    = 0;
	localparam int PRE_LSB   = 0;
	localparam int WM_HI_BIT = 3;
	localparam int DIR_A_BIT = 4;
	localparam int DIR_B_BIT = 5;
	localparam int DOWN_BIT  = 8;
	localparam int ST_OVF    = 0;
	localparam int ST_CMPA   = 1;
	localparam int ST_CMPB   = 2;

	// ------------------------------------------------------------
	// Reset values and codes
	// ------------------------------------------------------------
	localparam logic [7:0] CTL_RESET   = 8'h00;
	localparam logic [7:0] CMP_RESET   = 8'h00;
	localparam logic [2:0] MODE_PC_MAX = 3'h1;
	localparam logic [2:0] MODE_PC_CMP = 3'h5;
	localparam logic [7:0] TOP_FIXED   = 8'hff;
	localparam logic [7:0] BOTTOM      = 8'h00;
	localparam logic [1:0] OM_TOGGLE   = 2'h1;
	localparam logic [1:0] OM_NONINV   = 2'h2;
	localparam logic [1:0] OM_INV      = 2'h3;

	// Prescaler divisions minus one, for selects 1..5
	localparam logic [9:0] DIV_1_M1    = 10'h000;
	localparam logic [9:0] DIV_8_M1    = 10'h007;
	localparam logic [9:0] DIV_64_M1   = 10'h03f;
	localparam logic [9:0] DIV_256_M1  = 10'h0ff;
	localparam logic [9:0] DIV_1024_M1 = 10'h3ff;
endpackage : tpw_pkg

// >>> tpw_timer.sv
/*
 * Phase-correct PWM timer with two compare channels and AHB-Lite slave.
 * Assumes single-word AHB-Lite transfers on hclk; pins are driven
 * through output enables resolved outside.
 */
// The AHB-Lite register port was left to the implementer.
// Operation
// RULE_01: Phase-correct mode runs when waveform mode is 0x1 or 0x5.
// RULE_02: Counter goes up to TOP, then down to BOTTOM, repeatedly.
// RULE_03: TOP is 0xFF in mode 0x1, channel A compare in 0x5.
// RULE_04: Non-inverting: clear on up match, set on down match.
// RULE_05: Inverting: set on up match, clear on down match.
// RULE_06: Counter holds TOP for one tick, then decrements.
// RULE_07: Overflow flag sets each time the counter reaches BOTTOM.
// RULE_08: Output mode 0x2 gives non-inverted PWM, 0x3 inverted.
// RULE_09: Channel A toggles on match with low mode bit and high bit.
// RULE_10: Wave reaches pin only when the pin direction is output.
// RULE_11: Compare BOTTOM gives steady low, MAX steady high, inverted opposite.
// RULE_12: Compare leaving MAX forces the up-match level.
// RULE_13: Missed up match still gives the transition at BOTTOM.
// RULE_14: Fully synchronous to hclk, tick is a clock enable.
// RULE_15: Period is 510 ticks; tick divides by 1, 8, 64, 256, 1024.
// RULE_16: Control A at 0x44 (0x24 alias), fields 7:6, 5:4, 1:0.
// RULE_17: Compare equal TOP with high mode bit acts at TOP.
// RULE_18: Compare values buffered, loaded when counter is at TOP.
// RULE_19: Counter moves only on ticks, holds otherwise.
`timescale 1ns/1ps
module tpw_timer (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Waveform pins
	output logic             wave_pin_a,
	output logic             wave_pin_a_oe,
	output logic             wave_pin_b,
	output logic             wave_pin_b_oe,
	// Interrupt
	output logic             irq
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  ctl_a;
		logic [7:0]  ctl_b;
		logic [7:0]  buf_a;
		logic [7:0]  buf_b;
		logic [7:0]  cmp_a;
		logic [7:0]  cmp_b;
		logic [7:0]  cnt;
		logic        down;
		logic [9:0]  pre;
		logic        tick;
		logic        wave_a;
		logic        wave_b;
		logic        pin_a;
		logic        oe_a;
		logic        pin_b;
		logic        oe_b;
		logic [2:0]  stat;
		logic [2:0]  en;
		logic        irq;
		logic [7:0]  waddr;
		logic        wr_pend;
		logic [31:0] rdata;
		logic        ready;
	} tpw_state_type;

	tpw_state_type r_reg;
	tpw_state_type r_next;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Output after a match; up decides the slope
	function automatic logic f_match(
		input logic [1:0] om,
		input logic       up,
		input logic       tog_ok,
		input logic       cur
	);
		logic res;
		res = cur;
		unique case (om)
			tpw_pkg::OM_NONINV: res = !up;
			tpw_pkg::OM_INV:    res = up;
			tpw_pkg::OM_TOGGLE: res = tog_ok ? !cur : cur;
			default:            res = cur;
		endcase
		return res;
	endfunction : f_match

	function automatic logic [9:0] f_div(input logic [2:0] sel);
		logic [9:0] d;
		d = tpw_pkg::DIV_1_M1;
		unique case (sel)
			3'h2:    d = tpw_pkg::DIV_8_M1;
			3'h3:    d = tpw_pkg::DIV_64_M1;
			3'h4:    d = tpw_pkg::DIV_256_M1;
			3'h5:    d = tpw_pkg::DIV_1024_M1;
			default: d = tpw_pkg::DIV_1_M1;
		endcase
		return d;
	endfunction : f_div

	logic [2:0] mode_w;
	logic       pwm_w;
	logic [7:0] top_w;
	logic       at_top_w;
	logic       up_w;
	logic [1:0] om_a_w;
	logic [1:0] om_b_w;
	logic       match_a_w;
	logic       match_b_w;
	logic       acc_w;

	assign mode_w = {r_reg.ctl_b[tpw_pkg::WM_HI_BIT], r_reg.ctl_a[tpw_pkg::WM_LSB +: 2]};
	// RULE_01 mode decode
	assign pwm_w = (mode_w == tpw_pkg::MODE_PC_MAX) || (mode_w == tpw_pkg::MODE_PC_CMP);
	// RULE_03 top select
	assign top_w = (mode_w == tpw_pkg::MODE_PC_CMP) ? r_reg.cmp_a : tpw_pkg::TOP_FIXED;
	assign at_top_w = r_reg.cnt >= top_w;
	// RULE_17 match at top counts as down slope
	assign up_w = (r_reg.cnt == tpw_pkg::BOTTOM) || (!r_reg.down && !at_top_w);
	assign om_a_w = r_reg.ctl_a[tpw_pkg::OM_A_LSB +: 2];
	assign om_b_w = r_reg.ctl_a[tpw_pkg::OM_B_LSB +: 2];
	assign match_a_w = r_reg.cnt == r_reg.cmp_a;
	assign match_b_w = r_reg.cnt == r_reg.cmp_b;
	assign acc_w = hsel && hready && htrans[1];

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [9:0] lim;
		logic [2:0] sel;
		logic [2:0] set;
		logic [2:0] clr;
		lim = f_div(r_reg.ctl_b[tpw_pkg::PRE_LSB +: 3]);
		sel = r_reg.ctl_b[tpw_pkg::PRE_LSB +: 3];
		set = 3'h0;
		clr = 3'h0;
		r_next = r_reg;
		r_next.tick = 1'b0;

		// RULE_15 prescaler, select 0 or above 5 stops
		if (sel == 3'h0 || sel > 3'h5) begin
			r_next.pre = 10'h000;
		end else if (r_reg.pre >= lim) begin
			r_next.pre = 10'h000;
			r_next.tick = 1'b1;
		end else begin
			r_next.pre = r_reg.pre + 10'h001;
		end

		// RULE_14 tick used only as an enable
		if (r_reg.tick && pwm_w) begin
			// RULE_02 dual slope
			if (up_w && !at_top_w) begin
				r_next.down = 1'b0;
				r_next.cnt = r_reg.cnt + 8'h01;
			end else if (r_reg.cnt == tpw_pkg::BOTTOM) begin
				r_next.down = 1'b0;
			end else begin
				// RULE_06 top lasts one tick
				r_next.down = 1'b1;
				r_next.cnt = r_reg.cnt - 8'h01;
			end
			// RULE_07 overflow at bottom
			if (r_next.cnt == tpw_pkg::BOTTOM && r_reg.cnt != tpw_pkg::BOTTOM)
				set[tpw_pkg::ST_OVF] = 1'b1;
			// RULE_04 RULE_05 RULE_08 RULE_09 match actions
			if (match_a_w) begin
				set[tpw_pkg::ST_CMPA] = 1'b1;
				r_next.wave_a = f_match(om_a_w, up_w, r_reg.ctl_b[tpw_pkg::WM_HI_BIT], r_reg.wave_a);
			end
			if (match_b_w) begin
				set[tpw_pkg::ST_CMPB] = 1'b1;
				r_next.wave_b = f_match(om_b_w, up_w, 1'b0, r_reg.wave_b);
			end
			// RULE_11 RULE_13 period start level
			if (r_reg.cnt == tpw_pkg::BOTTOM) begin
				if (om_a_w[1] && !match_a_w)
					r_next.wave_a = !om_a_w[0];
				if (om_b_w[1] && !match_b_w)
					r_next.wave_b = !om_b_w[0];
			end
			if (at_top_w) begin
				// RULE_18 buffered compare load
				r_next.cmp_a = r_reg.buf_a;
				r_next.cmp_b = r_reg.buf_b;
				// RULE_12 leaving max
				if (om_a_w[1] && r_reg.cmp_a == tpw_pkg::TOP_FIXED && r_reg.buf_a != tpw_pkg::TOP_FIXED)
					r_next.wave_a = om_a_w[0];
				if (om_b_w[1] && r_reg.cmp_b == tpw_pkg::TOP_FIXED && r_reg.buf_b != tpw_pkg::TOP_FIXED)
					r_next.wave_b = om_b_w[0];
			end
		end
		// Other modes are not built: counter stands, compare loads at once
		if (!pwm_w) begin
			r_next.cmp_a = r_reg.buf_a;
			r_next.cmp_b = r_reg.buf_b;
		end

		// Bus: write takes effect one cycle after its address phase
		r_next.ready = 1'b1;
		r_next.wr_pend = 1'b0;
		if (r_reg.wr_pend) begin
			unique case (r_reg.waddr)
				tpw_pkg::ADDR_CTL_A,
				tpw_pkg::ADDR_CTL_A_IO: r_next.ctl_a = hwdata[7:0] & 8'hf3;
				tpw_pkg::ADDR_CTL_B:    r_next.ctl_b = hwdata[7:0] & 8'h3f;
				tpw_pkg::ADDR_CMP_A:    r_next.buf_a = hwdata[7:0];
				tpw_pkg::ADDR_CMP_B:    r_next.buf_b = hwdata[7:0];
				tpw_pkg::ADDR_COUNT:    r_next.cnt = hwdata[7:0];
				tpw_pkg::ADDR_CLEAR:    clr = hwdata[2:0];
				tpw_pkg::ADDR_ENABLE:   r_next.en = hwdata[2:0];
				default:                clr = 3'h0;
			endcase
		end
		r_next.rdata = 32'h0000_0000;
		if (acc_w && hwrite) begin
			// One wait state keeps a following read coherent
			r_next.wr_pend = 1'b1;
			r_next.ready = 1'b0;
			r_next.waddr = haddr[7:0];
		end else if (acc_w) begin
			unique case (haddr[7:0])
				tpw_pkg::ADDR_CTL_A,
				tpw_pkg::ADDR_CTL_A_IO: r_next.rdata[7:0] = r_reg.ctl_a;
				tpw_pkg::ADDR_CTL_B:    r_next.rdata[7:0] = r_reg.ctl_b;
				tpw_pkg::ADDR_CMP_A:    r_next.rdata[7:0] = r_reg.buf_a;
				tpw_pkg::ADDR_CMP_B:    r_next.rdata[7:0] = r_reg.buf_b;
				tpw_pkg::ADDR_COUNT:    r_next.rdata[8:0] = {r_reg.down, r_reg.cnt};
				tpw_pkg::ADDR_STATUS:   r_next.rdata[2:0] = r_reg.stat;
				tpw_pkg::ADDR_ENABLE:   r_next.rdata[2:0] = r_reg.en;
				default:                r_next.rdata = 32'h0000_0000;
			endcase
		end

		// Hardware set wins over software clear
		r_next.stat = (r_reg.stat & ~clr) | set;
		r_next.irq = |(r_next.stat & r_next.en);

		// RULE_10 pin gated by direction
		r_next.oe_a = r_reg.ctl_b[tpw_pkg::DIR_A_BIT] && (om_a_w[1] || (om_a_w[0] && r_reg.ctl_b[tpw_pkg::WM_HI_BIT]));
		// Disconnected modes keep a stale wave off the pin
		r_next.pin_a = r_next.oe_a && r_next.wave_a;
		r_next.oe_b = r_reg.ctl_b[tpw_pkg::DIR_B_BIT] && om_b_w[1];
		r_next.pin_b = r_next.oe_b && r_next.wave_b;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_reg <= '0;
			// RULE_16 control resets to zero
			r_reg.ctl_a <= tpw_pkg::CTL_RESET;
			r_reg.ctl_b <= tpw_pkg::CTL_RESET;
			r_reg.buf_a <= tpw_pkg::CMP_RESET;
			r_reg.buf_b <= tpw_pkg::CMP_RESET;
			r_reg.ready <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign hrdata = r_reg.rdata;
	assign hreadyout = r_reg.ready;
	assign hresp = 1'b0;
	assign wave_pin_a = r_reg.pin_a;
	assign wave_pin_a_oe = r_reg.oe_a;
	assign wave_pin_b = r_reg.pin_b;
	assign wave_pin_b_oe = r_reg.oe_b;
	assign irq = r_reg.irq;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic cnt_wr_w;
	assign cnt_wr_w = r_reg.wr_pend && r_reg.waddr == tpw_pkg::ADDR_COUNT;

	sequence s_step;
		r_reg.tick && pwm_w && !cnt_wr_w;
	endsequence
	sequence s_turn;
		s_step ##0 (!r_reg.down && r_reg.cnt == top_w && top_w != tpw_pkg::BOTTOM);
	endsequence
	sequence s_reach_bot;
		s_step ##0 (r_reg.down && r_reg.cnt == 8'h01);
	endsequence

	chk_idle_hold: assert property ( // RULE_19
		!(r_reg.tick && pwm_w) && !cnt_wr_w |=> $stable(r_reg.cnt))
		else $error("counter moved without a tick");
	chk_mode_gate: assert property ( // RULE_01
		!pwm_w && !cnt_wr_w |=> $stable(r_reg.cnt))
		else $error("counter ran outside pwm modes");
	chk_top_turn: assert property ( // RULE_06
		s_turn |=> r_reg.down && r_reg.cnt == $past(top_w) - 8'h01)
		else $error("no turn after top");
	chk_fixed_top: assert property ( // RULE_03
		s_step ##0 (mode_w == tpw_pkg::MODE_PC_MAX && !r_reg.down && r_reg.cnt == 8'hfe)
		|=> r_reg.cnt == tpw_pkg::TOP_FIXED)
		else $error("mode 1 top not reached");
	chk_ovf_flag: assert property ( // RULE_07
		s_reach_bot |=> r_reg.cnt == tpw_pkg::BOTTOM && r_reg.stat[tpw_pkg::ST_OVF]
		&& (irq || !r_reg.en[tpw_pkg::ST_OVF]))
		else $error("overflow flag missing");
	chk_up_clear: assert property ( // RULE_04
		s_step ##0 (up_w && match_a_w && om_a_w == tpw_pkg::OM_NONINV && r_reg.cnt != tpw_pkg::BOTTOM)
		|=> !r_reg.wave_a)
		else $error("non-inverting up match did not clear");
	chk_down_clear: assert property ( // RULE_05
		s_step ##0 (!up_w && match_b_w && om_b_w == tpw_pkg::OM_INV && !at_top_w)
		|=> !r_reg.wave_b)
		else $error("inverting down match did not clear");
	chk_toggle_a: assert property ( // RULE_09
		s_step ##0 (match_a_w && om_a_w == tpw_pkg::OM_TOGGLE && r_reg.ctl_b[tpw_pkg::WM_HI_BIT])
		|=> r_reg.wave_a != $past(r_reg.wave_a))
		else $error("toggle missing on channel a");
	chk_pin_gate: assert property ( // RULE_10
		!r_reg.ctl_b[tpw_pkg::DIR_A_BIT] |=> !wave_pin_a && !wave_pin_a_oe)
		else $error("pin driven while input");
	chk_buf_load: assert property ( // RULE_18
		s_step ##0 at_top_w |=> r_reg.cmp_b == $past(r_reg.buf_b))
		else $error("compare not loaded at top");
endmodule : tpw_timer

// >>> tb.sv
/*
 * Self-checking bench of the phase-correct PWM timer: AHB-Lite register
 * access, waveform duty counts, pin enables, prescaling and the interrupt.
 * Assumes the timer is the only slave, so hready is fed from hreadyout.
 */
`timescale 1ns/1ps
module tb;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        hclk         = 1'b0;
	logic        hresetn      = 1'b0;
	logic        hsel         = 1'b0;
	logic [31:0] haddr        = 32'h0;
	logic [1:0]  htrans       = 2'h0;
	logic        hwrite       = 1'b0;
	logic [2:0]  hsize        = 3'h0;
	logic [31:0] hwdata       = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        pin_a;
	logic        oe_a;
	logic        pin_b;
	logic        oe_b;
	logic        irq;
	logic [31:0] rd;
	int          miscompares  = 0;
	int          total_checks = 0;
	logic [7:0]  cmp_list [4] = '{8'h80, 8'hff, 8'h40, 8'h00};

	tpw_timer tpw_timer_inst (
		.hclk          (hclk),
		.hresetn       (hresetn),
		.hsel          (hsel),
		.haddr         (haddr),
		.htrans        (htrans),
		.hwrite        (hwrite),
		.hsize         (hsize),
		.hwdata        (hwdata),
		.hready        (hreadyout),
		.hrdata        (hrdata),
		.hreadyout     (hreadyout),
		.hresp         (hresp),
		.wave_pin_a    (pin_a),
		.wave_pin_a_oe (oe_a),
		.wave_pin_b    (pin_b),
		.wave_pin_b_oe (oe_b),
		.irq           (irq)
	);

	always #5 hclk = ~hclk;

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish

	// Sampling at the falling edge equals what the next rising edge sees
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(negedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			chk({31'h0, hreadyout}, 32'h1);
			tally_and_finish();
		end
		rd = hrdata;
		@(posedge hclk);
	endtask : wait_ready

	task automatic xfer(input logic wr_en, input logic [7:0] a, input logic [31:0] wd);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= wr_en;
		hsize  <= 3'h2;
		wait_ready();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd & m, e);
		chk({31'h0, hresp}, 32'h0);
	endtask : rdc

	task automatic settle(input int n);
		repeat (n) @(posedge hclk);
	endtask : settle

	// Counts high cycles of pins and enables; a negative pin A expectation skips its check
	task automatic meas(input int n, input int ea, input int eb, input int eoa, input int eob);
		int ha;
		int hb;
		int oa;
		int ob;
		ha = 0;
		hb = 0;
		oa = 0;
		ob = 0;
		repeat (n) begin
			@(negedge hclk);
			ha += (pin_a === 1'b1);
			hb += (pin_b === 1'b1);
			oa += (oe_a === 1'b1);
			ob += (oe_b === 1'b1);
		end
		@(posedge hclk);
		if (ea >= 0) begin
			chk(ha, ea);
		end
		chk(hb, eb);
		chk(oa, eoa);
		chk(ob, eob);
	endtask : meas

	task automatic irq_chk(input logic e);
		settle(2);
		@(negedge hclk);
		chk({31'h0, irq}, {31'h0, e});
		@(posedge hclk);
	endtask : irq_chk

	task automatic wait_irq();
		int n;
		n = 0;
		do begin
			@(negedge hclk);
			n++;
		end while (irq !== 1'b1 && n < 300);
		chk({31'h0, irq}, 32'h1);
		if (irq !== 1'b1) begin
			tally_and_finish();
		end
		@(posedge hclk);
	endtask : wait_irq

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		settle(20);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc(8'h44, 32'hff, 32'h0);
		rdc(8'h24, 32'hff, 32'h0);
		wr(8'h44, 32'hff);
		rdc(8'h44, 32'hff, 32'hf3);
		rdc(8'h24, 32'hff, 32'hf3);
		rdc(8'h7c, 32'hffffffff, 32'h0);
		// Mode 1, A non-inverted, B inverted, both pins driven
		wr(8'h44, 32'hb1);
		wr(8'h48, 32'h31);
		foreach (cmp_list[i]) begin
			wr(8'h4c, {24'h0, cmp_list[i]});
			wr(8'h50, {24'h0, cmp_list[i]});
			// Buffered compares only take effect at the next TOP
			settle(1100);
			meas(510, 2 * int'(cmp_list[i]), 510 - 2 * int'(cmp_list[i]), 510, 510);
		end
		wr(8'h48, 32'h01);
		settle(4);
		meas(510, 0, 0, 0, 0);
		wr(8'h48, 32'h30);
		wr(8'h54, 32'h37);
		settle(40);
		rdc(8'h54, 32'hff, 32'h37);
		wr(8'h4c, 32'h80);
		wr(8'h50, 32'h80);
		wr(8'h48, 32'h32);
		settle(8800);
		meas(4080, 2048, 2032, 4080, 4080);
		// Mode 5: TOP from compare A, period of 64 ticks
		wr(8'h4c, 32'h20);
		wr(8'h50, 32'h10);
		wr(8'h48, 32'h39);
		wr(8'h44, 32'ha1);
		settle(1100);
		meas(640, 640, 320, 640, 640);
		wr(8'h44, 32'h51);
		settle(300);
		meas(1280, 640, 0, 1280, 0);
		wr(8'h60, 32'h1);
		wr(8'h5c, 32'h7);
		wait_irq();
		wr(8'h48, 32'h38);
		rdc(8'h58, 32'h1, 32'h1);
		wr(8'h60, 32'h0);
		irq_chk(1'b0);
		wr(8'h60, 32'h1);
		irq_chk(1'b1);
		wr(8'h5c, 32'h1);
		irq_chk(1'b0);
		rdc(8'h58, 32'h1, 32'h0);
		tally_and_finish();
	end
endmodule : tb
